// ### pkg/fibl_cfg.svh
// Constants of the flash image boot loader: offsets, field positions, reset values.
// Assumes a 1MB flash read one byte per request and a byte-wide memory write port with 64-bit addresses.
`ifndef FIBL_CFG_SVH
`define FIBL_CFG_SVH
`define FIBL_SIG_LO          32'hA5A53C3C
`define FIBL_SIG_HI          32'h5A5AC3C3
`define FIBL_HDR_V0_SIZE     32'h00000020
`define FIBL_HDR_REV_REQ     8'h01
`define FIBL_OFS_SIG         8'h00
`define FIBL_OFS_HSIZE       8'h08
`define FIBL_OFS_ICSUM       8'h0C
`define FIBL_OFS_ISIZE       8'h10
`define FIBL_OFS_DEST        8'h14
`define FIBL_OFS_DECOMP      8'h1C
`define FIBL_OFS_HREV        8'h1D
`define FIBL_OFS_FWID        8'h1E
`define FIBL_OFS_HREVX       8'h1F
`define FIBL_OFS_HCSUM       8'h20
`define FIBL_FLASH_BYTES     21'h100000
`define FIBL_FLASH_AW        20
`define FIBL_RLE_ESC         8'hFF
`define FIBL_FW_DBM          8'h00
`define FIBL_FW_FSB          8'h06
`define FIBL_FW_MAX          8'h07
`define FIBL_REG_BANK        12'h800
`define FIBL_REG_STATUS      12'h804
`define FIBL_REG_DEST        12'h808
`define FIBL_REG_INFO        12'h80C
`define FIBL_REG_CTRL        12'h810
`define FIBL_BANK_RESET      8'h00
`endif

// ### pkg/fibl_pkg.sv
// Types of the flash image boot loader.
// Assumes the constants header is included by each user.
package fibl_pkg;
  typedef enum logic [2:0]
  {
    FIBL_PASS_STRICT = 3'b001,
    FIBL_PASS_NO_HDR = 3'b010,
    FIBL_PASS_NONE   = 3'b100
  } fibl_pass_t;
  typedef struct packed
  {
    logic [31:0] hsize;
    logic [31:0] icsum;
    logic [31:0] isize;
    logic [63:0] dest;
    logic [7:0]  decomp;
    logic [7:0]  hrev;
    logic [7:0]  fwid;
    logic [7:0]  hrevx;
    logic [7:0]  hcsum;
  } fibl_hdr_t;
  typedef struct packed
  {
    logic        req;
    logic [19:0] addr;
    logic        upper;
  } fibl_flash_req_t;
  typedef struct packed
  {
    logic        we;
    logic [63:0] addr;
    logic [7:0]  data;
  } fibl_mem_wr_t;
endpackage : fibl_pkg

// ### core/fibl_apb_regs.sv
// APB slave holding the bank select, status and control words of the loader.
// Assumes an APB master on core_clk; answers with zero wait states.
`timescale 1ns/1ns
`include "fibl_cfg.svh"
module fibl_apb_regs
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] status,
  input  wire logic [31:0] dest_lo,
  input  wire logic [31:0] info,
  output logic             bank_upper,
  output logic             restart_pulse
);
  logic [7:0]  bank_r;
  logic        acc;
  logic        setup;
  logic        known;
  logic [31:0] rd_word;
  assign acc = psel && penable;
  assign setup = psel && !penable;
  assign known = (paddr == `FIBL_REG_BANK) || (paddr == `FIBL_REG_STATUS) || (paddr == `FIBL_REG_DEST)
              || (paddr == `FIBL_REG_INFO) || (paddr == `FIBL_REG_CTRL);
  assign bank_upper = bank_r[0];
  // Answer flops load at the setup edge, so the access phase still needs no wait state.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= rd_word;
      pready  <= setup;
      pslverr <= setup && !known;
    end
  end
  // Only the low bit drives the bank line; the rest reads back as written.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      bank_r <= `FIBL_BANK_RESET;
    else if (acc && pwrite && paddr == `FIBL_REG_BANK)
      bank_r <= pwdata[7:0];
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      restart_pulse <= 1'b0;
    else
      restart_pulse <= acc && pwrite && paddr == `FIBL_REG_CTRL && pwdata[0];
  end
  always_comb
  begin
    case (paddr)
      `FIBL_REG_BANK:   rd_word = {24'h000000, bank_r};
      `FIBL_REG_STATUS: rd_word = status;
      `FIBL_REG_DEST:   rd_word = dest_lo;
      `FIBL_REG_INFO:   rd_word = info;
      default:          rd_word = 32'h00000000;
    endcase
  end
endmodule : fibl_apb_regs

// ### core/fibl_loader.sv
// Top of the loader: flash scan, copy with expansion, handover and APB registers.
// Assumes flash answers one byte per request with flash_ack; memory takes a byte each cycle.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`include "fibl_cfg.svh"
module fibl_loader
#(
  parameter int FLASH_BYTES = 1048576
)
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        first_image_select_jumper,
  input  wire logic        flash_write_enable_jumper,
  input  wire logic        sw_flash_we,
  output logic             flash_we_out,
  output fibl_pkg::fibl_flash_req_t flash_req,
  input  wire logic        flash_ack,
  input  wire logic [7:0]  flash_rdata,
  output fibl_pkg::fibl_mem_wr_t mem_wr,
  output logic             flash_upper_bank_addr_bit,
  output logic             cpu_start,
  output logic      [63:0] cpu_start_addr
);
  typedef enum logic [7:0]
  {
    S_IDLE  = 8'b00000001,
    S_SCAN  = 8'b00000010,
    S_HDR   = 8'b00000100,
    S_CHECK = 8'b00001000,
    S_COPY  = 8'b00010000,
    S_RUN   = 8'b00100000,
    S_NEXT  = 8'b01000000,
    S_RAW   = 8'b10000000
  } fibl_state_t;

  function automatic logic [7:0] fibl_csum(input logic [7:0] acc, input logic [7:0] b);
    fibl_csum = acc + b;
  endfunction : fibl_csum

  logic        rst_a_r;
  logic        rst_n;
  fibl_state_t st_r;
  fibl_pkg::fibl_pass_t pass_r;
  logic [19:0] addr_r;
  logic [19:0] hbase_r;
  logic [7:0]  hidx_r;
  logic [63:0] sig_r;
  fibl_pkg::fibl_hdr_t hdr_r;
  logic [7:0]  hsum_r;
  logic [1:0]  ord_r;
  logic        any_hdr_r;
  logic [31:0] left_r;
  logic [31:0] isum_r;
  logic [63:0] dptr_r;
  logic        rle_esc_r;
  logic [1:0]  rle_ph_r;
  logic [7:0]  rle_cnt_r;
  logic        done_r;
  logic        busy;
  logic        bank_upper;
  logic        restart;
  logic        hdr_ok;
  logic        want;
  logic [19:0] addr_inc;

  // The reset is released through two stages so every flop leaves reset on the same edge.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_a_r <= 1'b0;
      rst_n   <= 1'b0;
    end
    else
    begin
      rst_a_r <= 1'b1;
      rst_n   <= rst_a_r;
    end
  end

  fibl_apb_regs u_regs
  (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .status        ({21'h000000, done_r, busy, pass_r, st_r[5:0]}),
    .dest_lo       (cpu_start_addr[31:0]),
    .info          ({hdr_r.hrev + hdr_r.hrevx, hdr_r.fwid, hdr_r.decomp, hdr_r.hsize[7:0]}),
    .bank_upper    (bank_upper),
    .restart_pulse (restart)
  );

  assign busy = (st_r != S_IDLE) && (st_r != S_RUN);
  assign addr_inc = addr_r + 20'h00001;
  // Version zero headers pass whatever their revision byte holds, so only later versions are checked.
  assign hdr_ok = (hdr_r.hsize == `FIBL_HDR_V0_SIZE) || (hdr_r.hrev == `FIBL_HDR_REV_REQ);
  // Skip the first valid header unless the jumper asks for it; a lone header is skipped on every pass, ending in the raw load.
  assign want = first_image_select_jumper || ord_r != 2'b00;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      flash_upper_bank_addr_bit <= 1'b0;
    else
      flash_upper_bank_addr_bit <= bank_upper && !busy;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      flash_we_out <= 1'b0;
    else
      flash_we_out <= sw_flash_we && flash_write_enable_jumper && !busy;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= S_IDLE;
      pass_r <= fibl_pkg::FIBL_PASS_STRICT;
      addr_r <= 20'h00000;
      hbase_r <= 20'h00000;
      hidx_r <= 8'h00;
      sig_r <= 64'h0000000000000000;
      hdr_r <= '0;
      hsum_r <= 8'h00;
      ord_r <= 2'b00;
      any_hdr_r <= 1'b0;
      left_r <= 32'h00000000;
      isum_r <= 32'h00000000;
      dptr_r <= 64'h0000000000000000;
      rle_esc_r <= 1'b0;
      rle_ph_r <= 2'b00;
      rle_cnt_r <= 8'h00;
      done_r <= 1'b0;
      flash_req <= '0;
      mem_wr <= '0;
      cpu_start <= 1'b0;
      cpu_start_addr <= 64'h0000000000000000;
    end
    else
    begin
      mem_wr.we <= 1'b0;
      cpu_start <= 1'b0;
      flash_req.upper <= 1'b0;
      case (st_r)
        S_IDLE:
        begin
          if (!done_r || restart)
          begin
            st_r <= S_SCAN;
            addr_r <= 20'h00000;
            sig_r <= 64'h0000000000000000;
            ord_r <= 2'b00;
            flash_req.req <= 1'b1;
            flash_req.addr <= 20'h00000;
            done_r <= 1'b0;
            // A restart begins again from the strict pass with no header seen yet.
            pass_r <= fibl_pkg::FIBL_PASS_STRICT;
            any_hdr_r <= 1'b0;
          end
        end
        S_SCAN:
        begin
          if (flash_ack)
          begin
            sig_r <= {flash_rdata, sig_r[63:8]};
            if ({flash_rdata, sig_r[63:8]} == {`FIBL_SIG_HI, `FIBL_SIG_LO})
            begin
              any_hdr_r <= 1'b1;
              hbase_r <= addr_r - 20'h00007;
              hidx_r <= 8'h08;
              hsum_r <= 8'h00;
              st_r <= S_HDR;
            end
            else if (addr_inc == 20'h00000)
            begin
              // End of flash: step down to the next, more relaxed pass, or to the raw load after the last pass or when no header was seen.
              ord_r <= 2'b00;
              sig_r <= 64'h0000000000000000;
              if (!any_hdr_r || pass_r == fibl_pkg::FIBL_PASS_NONE)
              begin
                st_r <= S_RAW;
                dptr_r <= 64'h0000000000000000;
                left_r <= FLASH_BYTES;
              end
              else if (pass_r == fibl_pkg::FIBL_PASS_STRICT)
                pass_r <= fibl_pkg::FIBL_PASS_NO_HDR;
              else
                pass_r <= fibl_pkg::FIBL_PASS_NONE;
            end
            addr_r <= addr_inc;
            flash_req.addr <= addr_inc;
          end
        end
        S_HDR:
        begin
          if (flash_ack)
          begin
            if (hidx_r != `FIBL_OFS_HCSUM)
              hsum_r <= fibl_csum(hsum_r, flash_rdata);
            case (hidx_r)
              `FIBL_OFS_HSIZE + 8'h00: hdr_r.hsize[7:0]   <= flash_rdata;
              `FIBL_OFS_HSIZE + 8'h01: hdr_r.hsize[15:8]  <= flash_rdata;
              `FIBL_OFS_HSIZE + 8'h02: hdr_r.hsize[23:16] <= flash_rdata;
              `FIBL_OFS_HSIZE + 8'h03: hdr_r.hsize[31:24] <= flash_rdata;
              `FIBL_OFS_ICSUM + 8'h00: hdr_r.icsum[7:0]   <= flash_rdata;
              `FIBL_OFS_ICSUM + 8'h01: hdr_r.icsum[15:8]  <= flash_rdata;
              `FIBL_OFS_ICSUM + 8'h02: hdr_r.icsum[23:16] <= flash_rdata;
              `FIBL_OFS_ICSUM + 8'h03: hdr_r.icsum[31:24] <= flash_rdata;
              `FIBL_OFS_ISIZE + 8'h00: hdr_r.isize[7:0]   <= flash_rdata;
              `FIBL_OFS_ISIZE + 8'h01: hdr_r.isize[15:8]  <= flash_rdata;
              `FIBL_OFS_ISIZE + 8'h02: hdr_r.isize[23:16] <= flash_rdata;
              `FIBL_OFS_ISIZE + 8'h03: hdr_r.isize[31:24] <= flash_rdata;
              `FIBL_OFS_DECOMP: hdr_r.decomp <= flash_rdata;
              `FIBL_OFS_HREV:   hdr_r.hrev   <= flash_rdata;
              `FIBL_OFS_FWID:   hdr_r.fwid   <= flash_rdata;
              `FIBL_OFS_HREVX:  hdr_r.hrevx  <= flash_rdata;
              `FIBL_OFS_HCSUM:  hdr_r.hcsum  <= flash_rdata;
              default:
              begin
                if (hidx_r >= `FIBL_OFS_DEST && hidx_r < `FIBL_OFS_DEST + 8'h08)
                  hdr_r.dest <= {flash_rdata, hdr_r.dest[63:8]};
              end
            endcase
            if (hidx_r == `FIBL_OFS_HCSUM)
            begin
              // Drop the request while the header is judged, so no byte comes from a stale address.
              st_r <= S_CHECK;
              flash_req.req <= 1'b0;
            end
            hidx_r <= hidx_r + 8'h01;
            addr_r <= hbase_r + {12'h000, hidx_r} + 20'h00001;
            flash_req.addr <= hbase_r + {12'h000, hidx_r} + 20'h00001;
          end
        end
        S_CHECK:
        begin
          // Image start follows the declared header size; extra header bytes are skipped.
          addr_r <= hbase_r + hdr_r.hsize[19:0];
          flash_req.addr <= hbase_r + hdr_r.hsize[19:0];
          dptr_r <= hdr_r.dest;
          left_r <= hdr_r.isize;
          isum_r <= 32'h00000000;
          rle_esc_r <= 1'b0;
          rle_ph_r <= 2'b00;
          if (!hdr_ok)
            st_r <= S_NEXT;
          else if (pass_r == fibl_pkg::FIBL_PASS_STRICT && hsum_r != hdr_r.hcsum)
            st_r <= S_NEXT;
          else if (!want)
          begin
            ord_r <= ord_r + 2'b01;
            st_r <= S_NEXT;
          end
          else
          begin
            st_r <= S_COPY;
            flash_req.req <= 1'b1;
          end
        end
        S_COPY:
        begin
          if (left_r == 32'h00000000 && rle_cnt_r == 8'h00)
          begin
            // Handover only with a matching image sum, unless the last pass ignores it.
            if (pass_r == fibl_pkg::FIBL_PASS_NONE || isum_r == hdr_r.icsum)
              st_r <= S_RUN;
            else
              st_r <= S_NEXT;
            flash_req.req <= 1'b0;
          end
          // Expansion waits until the value byte of the run has been fetched.
          else if (rle_cnt_r != 8'h00 && rle_ph_r == 2'b00)
          begin
            mem_wr.we <= 1'b1;
            mem_wr.addr <= dptr_r;
            dptr_r <= dptr_r + 64'h0000000000000001;
            rle_cnt_r <= rle_cnt_r - 8'h01;
          end
          else if (flash_ack)
          begin
            isum_r <= isum_r + {24'h000000, flash_rdata};
            left_r <= left_r - 32'h00000001;
            addr_r <= addr_inc;
            flash_req.addr <= addr_inc;
            if (hdr_r.decomp == 8'h00)
            begin
              mem_wr.we <= 1'b1;
              mem_wr.addr <= dptr_r;
              mem_wr.data <= flash_rdata;
              dptr_r <= dptr_r + 64'h0000000000000001;
            end
            else if (rle_ph_r == 2'b00 && flash_rdata != `FIBL_RLE_ESC)
            begin
              mem_wr.we <= 1'b1;
              mem_wr.addr <= dptr_r;
              mem_wr.data <= flash_rdata;
              dptr_r <= dptr_r + 64'h0000000000000001;
            end
            else if (rle_ph_r == 2'b00)
              rle_ph_r <= 2'b01;
            else if (rle_ph_r == 2'b01)
            begin
              rle_cnt_r <= flash_rdata;
              rle_ph_r <= 2'b10;
            end
            else
            begin
              mem_wr.data <= flash_rdata;
              rle_ph_r <= 2'b00;
            end
          end
        end
        S_NEXT:
        begin
          // Resume the signature hunt just past the signature of the rejected or skipped header.
          st_r <= S_SCAN;
          sig_r <= 64'h0000000000000000;
          addr_r <= hbase_r + 20'h00008;
          flash_req.addr <= hbase_r + 20'h00008;
          flash_req.req <= 1'b1;
        end
        S_RAW:
        begin
          if (left_r == 32'h00000000)
          begin
            flash_req.req <= 1'b0;
            hdr_r.dest <= 64'h0000000000000000;
            st_r <= S_RUN;
          end
          else if (flash_ack)
          begin
            mem_wr.we <= 1'b1;
            mem_wr.addr <= dptr_r;
            mem_wr.data <= flash_rdata;
            dptr_r <= dptr_r + 64'h0000000000000001;
            left_r <= left_r - 32'h00000001;
            addr_r <= addr_inc;
            flash_req.addr <= addr_inc;
          end
        end
        S_RUN:
        begin
          cpu_start <= 1'b1;
          cpu_start_addr <= hdr_r.dest;
          done_r <= 1'b1;
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  chk_bank_reset: assert property (@(posedge core_clk) $rose(rst_n) |-> !flash_upper_bank_addr_bit)
    else $error("bank bit not low after reset");
  chk_bank_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    !busy && $stable(bank_upper) && !$past(busy) |=> flash_upper_bank_addr_bit == $past(bank_upper))
    else $error("bank bit does not follow register");
  chk_write_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    flash_we_out |-> $past(flash_write_enable_jumper))
    else $error("flash write without jumper");
  chk_run_sum: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_r == S_RUN && $past(st_r) == S_COPY && pass_r != fibl_pkg::FIBL_PASS_NONE |-> isum_r == hdr_r.icsum)
    else $error("handover with bad image sum");
  chk_start_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_r == S_RUN |=> cpu_start && cpu_start_addr == $past(hdr_r.dest))
    else $error("start address mismatch");
  chk_raw_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_r == S_RAW && mem_wr.we && $past(left_r) == FLASH_BYTES |-> mem_wr.addr == 64'h0000000000000000)
    else $error("raw load not at zero");
  chk_scan_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_r == S_IDLE && !done_r |=> flash_req.addr == 20'h00000)
    else $error("scan does not start at zero");
  chk_strict_hsum: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_r == S_CHECK && pass_r == fibl_pkg::FIBL_PASS_STRICT && hsum_r != hdr_r.hcsum |=> st_r == S_NEXT)
    else $error("bad header sum accepted");
  cov_run: cover property (@(posedge core_clk) cpu_start);
  cov_raw: cover property (@(posedge core_clk) st_r == S_RAW);
  cov_relax: cover property (@(posedge core_clk) pass_r == fibl_pkg::FIBL_PASS_NONE);
endmodule : fibl_loader

// ### sim/fibl_flash_model.sv
// Behavioural flash ROM that answers one byte per request after a random delay.
// Assumes the loader holds its request address until it sees the acknowledge.
`timescale 1ns/1ns
module fibl_flash_model
(
  input  wire fibl_pkg::fibl_flash_req_t flash_req,
  input  wire logic                      core_clk,
  output logic                           flash_ack,
  output logic [7:0]                     flash_rdata
);
  bit   [7:0] mem [0:1048575];
  int         wait_r;
  initial
  begin
    flash_ack   = 1'b0;
    flash_rdata = 8'h00;
    wait_r      = 0;
  end
  // A released data bus inverts its value on every idle cycle, so stale data never passes as valid.
  always @(posedge core_clk)
  begin
    if (flash_req.req && !flash_ack && wait_r == 0)
    begin
      flash_ack   <= 1'b1;
      flash_rdata <= mem[flash_req.addr];
      wait_r      <= $urandom_range(0, 2);
    end
    else
    begin
      flash_ack   <= 1'b0;
      flash_rdata <= ~flash_rdata;
      if (wait_r != 0)
        wait_r <= wait_r - 1;
    end
  end
endmodule : fibl_flash_model

// ### sim/flash_image_boot_loader_tb_top.sv
// Self-checking bench: two images in flash, jumper selection, registers and write gating.
// Assumes the flash model file and the loader with its constants header are compiled first.
`timescale 1ns/1ns
`include "fibl_cfg.svh"
module flash_image_boot_loader_tb_top;
  logic                      core_clk;
  logic                      resetn;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [11:0]               paddr;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic                      jmp_first;
  logic                      jmp_we;
  logic                      sw_we;
  logic                      we_out;
  fibl_pkg::fibl_flash_req_t flash_req;
  logic                      flash_ack;
  logic [7:0]                flash_rdata;
  fibl_pkg::fibl_mem_wr_t    mem_wr;
  logic                      bank_bit;
  logic                      cpu_start;
  logic [63:0]               start_addr;
  logic [71:0]               exp_q[$];
  logic [63:0]               start_q[$];
  int                        bad_count;
  int                        cmp_count;
  int                        start_cnt;
  logic [31:0]               rd;
  logic                      err;
  fibl_loader #(.FLASH_BYTES(1048576)) i_fibl_loader
  (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_image_select_jumper(jmp_first), .flash_write_enable_jumper(jmp_we), .sw_flash_we(sw_we),
    .flash_we_out(we_out), .flash_req(flash_req), .flash_ack(flash_ack), .flash_rdata(flash_rdata),
    .mem_wr(mem_wr), .flash_upper_bank_addr_bit(bank_bit), .cpu_start(cpu_start),
    .cpu_start_addr(start_addr)
  );
  fibl_flash_model i_fibl_flash_model
  (
    .flash_req(flash_req), .core_clk(core_clk), .flash_ack(flash_ack), .flash_rdata(flash_rdata)
  );
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task chk(input logic [71:0] seen, input logic [71:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task stop_test;
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      chk(72'h1, 72'h0);
      stop_test;
    end
  endtask : apb
  // The header carries version one layout so the checksum byte sits inside the header block.
  task automatic put_hdr(input int b, input logic [7:0] fw, input logic [7:0] dc, input logic [63:0] d,
                         input logic [7:0] img[$]);
    logic [7:0]  h[0:31];
    logic [31:0] s;
    s = 0;
    foreach (img[i]) s += img[i];
    for (int i = 0; i < 8; i++) h[i] = 8'({`FIBL_SIG_HI, `FIBL_SIG_LO} >> (8 * i));
    for (int i = 0; i < 4; i++)
    begin
      h[8 + i]  = 8'(32'h24 >> (8 * i));
      h[12 + i] = 8'(s >> (8 * i));
      h[16 + i] = 8'(img.size() >> (8 * i));
    end
    for (int i = 0; i < 8; i++) h[20 + i] = 8'(d >> (8 * i));
    h[28] = dc;
    h[29] = `FIBL_HDR_REV_REQ;
    h[30] = fw;
    h[31] = 8'h00;
    s = 0;
    for (int i = 8; i < 32; i++) s += h[i];
    for (int i = 0; i < 32; i++) i_fibl_flash_model.mem[b + i] = h[i];
    i_fibl_flash_model.mem[b + 32] = s[7:0];
    foreach (img[i]) i_fibl_flash_model.mem[b + 36 + i] = img[i];
  endtask : put_hdr
  task automatic expect_img(input logic [63:0] d, input logic [7:0] dc, input logic [7:0] img[$]);
    int k;
    k = 0;
    for (int i = 0; i < img.size(); i++)
      if (dc != 8'h00 && img[i] == `FIBL_RLE_ESC)
      begin
        for (int j = 0; j < img[i + 1]; j++)
        begin
          exp_q.push_back({d + 64'(k), img[i + 2]});
          k++;
        end
        i += 2;
      end
      else
      begin
        exp_q.push_back({d + 64'(k), img[i]});
        k++;
      end
    start_q.push_back(d);
  endtask : expect_img
  task wait_start;
    int n;
    n = start_cnt;
    for (int i = 0; i < 20000 && start_cnt == n; i++) @(posedge core_clk);
    if (start_cnt == n)
    begin
      bad_count++;
      stop_test;
    end
  endtask : wait_start
  always @(posedge core_clk)
  begin
    if (resetn && mem_wr.we === 1'b1)
      chk({mem_wr.addr, mem_wr.data}, exp_q.size() ? exp_q.pop_front() : ~{mem_wr.addr, mem_wr.data});
    if (resetn && cpu_start === 1'b1)
    begin
      chk(exp_q.size(), 0);
      chk(start_addr, start_q.size() ? start_q.pop_front() : ~start_addr);
      start_cnt++;
    end
  end
  initial
  begin
    logic [7:0]  img_a[$];
    logic [7:0]  img_b[$];
    logic [63:0] dest_b;
    {resetn, psel, penable, pwrite, paddr, pwdata, jmp_first, jmp_we, sw_we} = '0;
    void'($urandom(97249));
    for (int i = 0; i < 4; i++) img_a.push_back(8'($urandom_range(0, 254)));
    img_b = {8'($urandom_range(0, 254)), 8'($urandom_range(0, 254)), `FIBL_RLE_ESC, 8'h05, 8'($urandom_range(0, 254))};
    dest_b = {32'h0, 16'h0002, 16'($urandom)};
    put_hdr(0, `FIBL_FW_FSB, 8'h00, 64'h1000, img_a);
    put_hdr(64, `FIBL_FW_DBM, 8'h01, dest_b, img_b);
    expect_img(dest_b, 8'h01, img_b);
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    wait_start;
    apb(1'b0, `FIBL_REG_STATUS, 32'h0);
    chk(rd[10:6], {2'b10, fibl_pkg::FIBL_PASS_STRICT});
    apb(1'b0, `FIBL_REG_DEST, 32'h0);
    chk(rd, dest_b[31:0]);
    apb(1'b0, `FIBL_REG_INFO, 32'h0);
    chk(rd, 32'h01000124);
    apb(1'b0, `FIBL_REG_BANK, 32'h0);
    chk({bank_bit, rd}, 33'h0);
    apb(1'b1, `FIBL_REG_BANK, 32'h1);
    apb(1'b0, `FIBL_REG_BANK, 32'h0);
    chk({bank_bit, rd[7:0]}, 9'h101);
    apb(1'b1, `FIBL_REG_BANK, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(bank_bit, 1'b0);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    sw_we <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(we_out, 1'b0);
    jmp_we <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(we_out, 1'b1);
    sw_we     <= 1'b0;
    jmp_first <= 1'b1;
    expect_img(64'h1000, 8'h00, img_a);
    apb(1'b1, `FIBL_REG_CTRL, 32'h1);
    wait_start;
    apb(1'b0, `FIBL_REG_INFO, 32'h0);
    chk(rd, 32'h01060024);
    stop_test;
  end
endmodule : flash_image_boot_loader_tb_top
